// ===== design/pwr_sfr_pkg.sv
// package for the power status and wake interrupt enable register bank
// assumes an 8-bit special function register bus clocked by the core clock
package pwr_sfr_pkg;

    // register addresses on the special function bus
    localparam logic [7:0] ADDR_POWER_IRQ_ENABLE  = 8'hEC;
    localparam logic [7:0] ADDR_PERIPHERAL_CONFIG = 8'hF4;
    localparam logic [7:0] ADDR_ADC_START_REGISTER = 8'hD8;

    // peripheral_config bit positions
    localparam int POS_UART2_WAKE   = 7;
    localparam int POS_SUPPLY_SRC   = 6;
    localparam int POS_MAIN_READY   = 5;
    localparam int POS_PLL_LOST     = 4;
    localparam int POS_REF_ENABLE   = 3;
    localparam int POS_RSVD_PERIPHERAL_CONFIG  = 2;
    localparam int POS_RXFUNC_HI    = 1;
    localparam int POS_RXFUNC_LO    = 0;

    // adc_start_register acknowledge bit
    localparam int POS_PLL_ACK      = 7;

    // power_irq_enable bit positions
    localparam int POS_EN_RESTORE   = 7;
    localparam int POS_EN_DIP       = 5;
    localparam int POS_EN_RSVD      = 4;
    localparam int POS_EN_DCIN_ADC  = 3;
    localparam int POS_EN_BATTERY   = 2;
    localparam int POS_EN_SWITCH    = 1;
    localparam int POS_EN_DCIN_LOW  = 0;

    // flag register bit of the power-management interrupt flag
    localparam int POS_POWER_IRQ_FLAG = 6;

    // writable enable bit mask and interrupt source flag mask
    localparam logic [7:0] MASK_ENABLE_WR = 8'hAF;
    localparam logic [7:0] MASK_FLAGS     = 8'hAF;

    // reset values
    localparam logic [7:0] RST_ENABLE     = 8'h00;
    localparam logic [1:0] RST_RXFUNC     = 2'h0;
    localparam logic       RST_SUPPLY_SRC = 1'b1;
    localparam logic       RST_MAIN_READY = 1'b1;
    localparam logic [7:0] RST_DATA       = 8'h00;

    // receive pin function codes
    typedef enum logic [1:0] {
        RXF_GPIO      = 2'h0,
        RXF_UART_NOWK = 2'h1,
        RXF_RSVD      = 2'h2,
        RXF_UART_WAKE = 2'h3
    } rx_func_t;

    // special function bus request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;

    // power monitor inputs from the analog side
    typedef struct packed {
        logic sup_from_main;
        logic main_ready;
        logic pll_unlock;
        logic rx_edge;
        logic deep_sleep;
    } pwr_mon_t;

endpackage

// ===== design/sticky_flag.sv
// single sticky status flag: set by hardware, cleared by a qualified pulse
// assumes set and clear are synchronous one-cycle strobes
`timescale 1ns/10ps
module sticky_flag (
    input  wire logic i_sys_clk,   // core clock
    input  wire logic i_sys_rst,   // synchronous reset, active high
    input  wire logic i_set,       // hardware event
    input  wire logic i_clr,       // software acknowledge
    output logic      o_flag       // sticky flag
);
    logic flag_reg;   // stored flag
    logic flag_next;  // next flag

    // set beats clear in the same cycle
    always_comb begin
        flag_next = flag_reg;
        if (i_clr) begin
            flag_next = 1'b0;
        end
        if (i_set) begin
            flag_next = 1'b1;
        end
    end

    // register stage
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign o_flag = flag_reg;
endmodule // sticky_flag

// ===== design/power_status_wake_irq_enable.sv
// power status, wake source and power interrupt enable register bank
// assumes a synchronous single-cycle special function bus, read data
// registered one cycle after the read strobe, monitor inputs synchronous
`timescale 1ns/10ps
module power_status_wake_irq_enable (
    input  wire logic                  i_sys_clk,        // core clock 250 MHz
    input  wire logic                  i_sys_rst,        // sync reset, high
    input  wire pwr_sfr_pkg::sfr_req_t i_sfr,            // bus request
    input  wire pwr_sfr_pkg::pwr_mon_t i_mon,            // power monitors
    input  wire logic [7:0]            i_flags,          // flag register
    output logic [7:0]                 o_rdata,          // read data
    output logic                       o_rvalid,         // read data valid
    output logic                       o_power_irq,      // interrupt request
    output logic                       o_power_irq_flag, // flag set strobe
    output logic                       o_restore_set,    // restore flag set
    output logic                       o_ref_keep_on,    // reference in sleep
    output logic                       o_rx_uart_sel,    // pin is uart rx
    output logic                       o_rx_wake_en      // rx wake enabled
);
    import pwr_sfr_pkg::*;

    // register state
    logic [7:0] enable_reg;      // power_irq_enable
    logic [7:0] enable_next;
    logic       ref_en_reg;      // lowpower_reference_enable
    logic       ref_en_next;
    logic [1:0] rxfunc_reg;      // receive_pin_function
    logic [1:0] rxfunc_next;
    logic       src_reg;         // supply_source_indicator
    logic       src_next;
    logic       ready_reg;       // main ready mirror
    logic       ready_next;
    logic [7:0] rdata_reg;       // read data
    logic [7:0] rdata_next;
    logic       rvalid_reg;
    logic       rvalid_next;
    logic       irq_reg;         // interrupt request
    logic       irq_next;
    logic       irqf_reg;        // interrupt flag set strobe
    logic       irqf_next;
    logic       restore_reg;     // restore flag set strobe
    logic       restore_next;
    logic       refout_reg;
    logic       refout_next;
    logic       uartsel_reg;
    logic       uartsel_next;
    logic       wake_reg;
    logic       wake_next;
    logic       irq_prev_reg;    // last cycle condition
    logic       irq_prev_next;

    // decoded strobes and sticky flags
    logic       wr_peripheral_config;       // write peripheral_config
    logic       wr_enable;       // write power_irq_enable
    logic       pll_ack;         // acknowledge write
    logic       wake_set;        // uart wake event
    logic       uart_wake;       // uart2_wake_status
    logic       pll_lost;        // pll_lock_lost
    logic       irq_cond;        // any enabled flag
    logic [7:0] peripheral_config_view;     // assembled config value
    rx_func_t   rx_func;         // decoded field

    // one sticky cell per event flag
    sticky_flag u_wake_flag (
        .i_sys_clk (i_sys_clk),
        .i_sys_rst (i_sys_rst),
        .i_set     (wake_set),
        .i_clr     (1'b0),
        .o_flag    (uart_wake)
    );

    sticky_flag u_pll_flag (
        .i_sys_clk (i_sys_clk),
        .i_sys_rst (i_sys_rst),
        .i_set     (i_mon.pll_unlock),
        .i_clr     (pll_ack),
        .o_flag    (pll_lost)
    );

    // bus decode and event qualification
    always_comb begin
        wr_peripheral_config = i_sfr.wr && (i_sfr.addr == ADDR_PERIPHERAL_CONFIG);
        wr_enable = i_sfr.wr && (i_sfr.addr == ADDR_POWER_IRQ_ENABLE);
        pll_ack   = i_sfr.wr && (i_sfr.addr == ADDR_ADC_START_REGISTER)
                    && i_sfr.wdata[POS_PLL_ACK];
        rx_func   = rx_func_t'(rxfunc_reg);
        // wake only counts in deep sleep with wake-enabled receive
        wake_set  = i_mon.rx_edge && i_mon.deep_sleep
                    && (rx_func == RXF_UART_WAKE);
        // each enable gates its own flag
        // for the other enable bits
        irq_cond  = |(enable_reg & i_flags & MASK_FLAGS);
        peripheral_config_view = {uart_wake, src_reg, ready_reg, pll_lost,
                       ref_en_reg, 1'b0, rxfunc_reg};
    end

    // next state of software fields and outputs
    always_comb begin
        enable_next   = enable_reg;
        ref_en_next   = ref_en_reg;
        rxfunc_next   = rxfunc_reg;
        rdata_next    = rdata_reg;
        rvalid_next   = 1'b0;
        // only writable bits are stored, status bits ignored
        if (wr_enable) begin
            enable_next = i_sfr.wdata & MASK_ENABLE_WR;
        end
        if (wr_peripheral_config) begin
            ref_en_next = i_sfr.wdata[POS_REF_ENABLE];
            rxfunc_next = i_sfr.wdata[POS_RXFUNC_HI:POS_RXFUNC_LO];
        end
        // read mux
        if (i_sfr.rd) begin
            rvalid_next = 1'b1;
            unique case (i_sfr.addr)
                ADDR_PERIPHERAL_CONFIG: rdata_next = peripheral_config_view;
                ADDR_POWER_IRQ_ENABLE:  rdata_next = enable_reg;
                default:                rdata_next = RST_DATA;
            endcase
        end
        src_next      = i_mon.sup_from_main;
        ready_next    = i_mon.main_ready;
        // restore on battery to main transition
        restore_next  = i_mon.sup_from_main && !src_reg;
        irq_next      = irq_cond;
        // flag set when the OR of all enabled sources rises, not on each source
        irqf_next     = irq_cond && !irq_prev_reg;
        irq_prev_next = irq_cond;
        refout_next   = ref_en_reg;
        // decode pin function
        unique case (rx_func)
            RXF_GPIO: begin
                uartsel_next = 1'b0;
                wake_next    = 1'b0;
            end
            RXF_UART_NOWK: begin
                uartsel_next = 1'b1;
                wake_next    = 1'b0;
            end
            RXF_UART_WAKE: begin
                uartsel_next = 1'b1;
                wake_next    = 1'b1;
            end
            default: begin
                // undefined code treated as gpio
                uartsel_next = 1'b0;
                wake_next    = 1'b0;
            end
        endcase
    end

    // register stage
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            enable_reg   <= RST_ENABLE;
            ref_en_reg   <= 1'b0;
            rxfunc_reg   <= RST_RXFUNC;
            src_reg      <= RST_SUPPLY_SRC;
            ready_reg    <= RST_MAIN_READY;
            rdata_reg    <= RST_DATA;
            rvalid_reg   <= 1'b0;
            irq_reg      <= 1'b0;
            irqf_reg     <= 1'b0;
            restore_reg  <= 1'b0;
            refout_reg   <= 1'b0;
            uartsel_reg  <= 1'b0;
            wake_reg     <= 1'b0;
            irq_prev_reg <= 1'b0;
        end else begin
            enable_reg   <= enable_next;
            ref_en_reg   <= ref_en_next;
            rxfunc_reg   <= rxfunc_next;
            src_reg      <= src_next;
            ready_reg    <= ready_next;
            rdata_reg    <= rdata_next;
            rvalid_reg   <= rvalid_next;
            irq_reg      <= irq_next;
            irqf_reg     <= irqf_next;
            restore_reg  <= restore_next;
            refout_reg   <= refout_next;
            uartsel_reg  <= uartsel_next;
            wake_reg     <= wake_next;
            irq_prev_reg <= irq_prev_next;
        end
    end

    // outputs straight from flip-flops
    assign o_rdata          = rdata_reg;
    assign o_rvalid         = rvalid_reg;
    assign o_power_irq      = irq_reg;
    assign o_power_irq_flag = irqf_reg;
    assign o_restore_set    = restore_reg;
    assign o_ref_keep_on    = refout_reg;
    assign o_rx_uart_sel    = uartsel_reg;
    assign o_rx_wake_en     = wake_reg;
endmodule // power_status_wake_irq_enable

// ===== test/power_status_wake_irq_enable_properties.sv
// checker for the power status and interrupt enable register bank
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/10ps
module power_status_wake_irq_enable_properties (
    input wire logic                  i_sys_clk,        // core clock
    input wire logic                  i_sys_rst,        // sync reset, high
    input wire pwr_sfr_pkg::sfr_req_t i_sfr,            // bus request
    input wire pwr_sfr_pkg::pwr_mon_t i_mon,            // monitors
    input wire logic [7:0]            i_flags,          // flag register
    input wire logic [7:0]            o_rdata,          // read data
    input wire logic                  o_rvalid,         // read valid
    input wire logic                  o_power_irq,      // interrupt request
    input wire logic                  o_power_irq_flag, // flag set strobe
    input wire logic                  o_restore_set,    // restore strobe
    input wire logic                  o_ref_keep_on,    // reference in sleep
    input wire logic                  o_rx_uart_sel,    // pin is uart rx
    input wire logic                  o_rx_wake_en      // rx wake enabled
);
    import pwr_sfr_pkg::*;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    // read of an address outside the bank
    sequence s_rd_unmapped;
        i_sfr.rd && i_sfr.addr != ADDR_POWER_IRQ_ENABLE && i_sfr.addr != ADDR_PERIPHERAL_CONFIG;
    endsequence
    // supply source leaves battery and returns to main
    sequence s_back_to_main;
        !i_mon.sup_from_main ##1 i_mon.sup_from_main;
    endsequence
    a_read_answers: assert property (i_sfr.rd |=> o_rvalid)
        else $error("read strobe not answered");
    a_idle_no_valid: assert property (!i_sfr.rd |=> !o_rvalid)
        else $error("read valid without a read");
    a_unmapped_reads_zero: assert property (s_rd_unmapped |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_enable_rsvd_zero: assert property (i_sfr.rd && i_sfr.addr == ADDR_POWER_IRQ_ENABLE
        |=> o_rdata[6] == 1'b0 && o_rdata[4] == 1'b0)
        else $error("reserved enable bits read as one");
    a_config_rsvd_zero: assert property (i_sfr.rd && i_sfr.addr == ADDR_PERIPHERAL_CONFIG
        |=> !o_rdata[2])
        else $error("reserved config bit read as one");
    a_irq_needs_flag: assert property (o_power_irq |-> ($past(i_flags) & MASK_FLAGS) != 8'h00)
        else $error("interrupt without a flag");
    a_irq_drops_clear: assert property ((i_flags & MASK_FLAGS) == 8'h00 |=> !o_power_irq)
        else $error("interrupt held without a flag");
    a_flag_on_rise: assert property ($rose(o_power_irq) |-> o_power_irq_flag)
        else $error("interrupt flag strobe missing");
    a_flag_one_cycle: assert property (o_power_irq_flag |-> o_power_irq ##1 !o_power_irq_flag)
        else $error("interrupt flag strobe too long");
    a_restore_strobe: assert property (s_back_to_main |-> ##[0:2] o_restore_set)
        else $error("restore strobe missing");
    a_restore_single: assert property (o_restore_set |=> !o_restore_set)
        else $error("restore strobe too long");
    a_wake_needs_uart: assert property (o_rx_wake_en |-> o_rx_uart_sel)
        else $error("wake enabled on gpio pin");
endmodule // power_status_wake_irq_enable_properties

bind power_status_wake_irq_enable power_status_wake_irq_enable_properties u_props (
    .i_sys_clk, .i_sys_rst, .i_sfr, .i_mon, .i_flags, .o_rdata, .o_rvalid, .o_power_irq,
    .o_power_irq_flag, .o_restore_set, .o_ref_keep_on, .o_rx_uart_sel, .o_rx_wake_en
);

// ===== test/testbench.sv
// directed testbench for the power status and interrupt enable bank
// assumes the design package is compiled first; bus driven by tasks
`timescale 1ns/10ps
module testbench;
    import pwr_sfr_pkg::*;
    logic       i_sys_clk;   // core clock
    logic       i_sys_rst;   // sync reset
    sfr_req_t   sfr;         // bus request
    pwr_mon_t   mon;         // monitor inputs
    logic [7:0] flags;       // flag register stand-in
    logic [7:0] rdata;       // read data
    logic       rvalid;      // read valid
    logic       irq;         // interrupt request
    logic       irq_flag;    // interrupt flag set strobe
    logic       restore;     // restore strobe
    logic       ref_on;      // reference keep-on
    logic       rx_sel;      // uart select
    logic       rx_wake;     // wake enable
    int         n_fail;      // mismatches
    int         num_checks;  // comparisons
    int         pos[6] = '{7, 5, 3, 2, 1, 0}; // enable positions
    power_status_wake_irq_enable dut (
        .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_sfr(sfr), .i_mon(mon),
        .i_flags(flags), .o_rdata(rdata), .o_rvalid(rvalid), .o_power_irq(irq),
        .o_power_irq_flag(irq_flag), .o_restore_set(restore), .o_ref_keep_on(ref_on),
        .o_rx_uart_sel(rx_sel), .o_rx_wake_en(rx_wake));
    // clock generator, 4 ns period
    initial begin
        i_sys_clk = 1'b0;
        forever #2 i_sys_clk = ~i_sys_clk;
    end
    // compare and count
    task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one bus write
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge i_sys_clk) sfr <= {1'b1, 1'b0, a, d};
        @(posedge i_sys_clk) sfr <= '0;
    endtask
    // one bus read, answer one cycle after the strobe
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        @(posedge i_sys_clk) sfr <= {1'b0, 1'b1, a, 8'h00};
        @(posedge i_sys_clk) sfr <= '0;
        #1;
        chk("rvalid", {7'h00, rvalid}, 8'h01);
        chk("rdata", rdata, exp);
    endtask
    // verdict and end of run
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        repeat (5000) @(posedge i_sys_clk);
        n_fail++;
        test_done();
    end
    // main sequence
    initial begin
        n_fail = 0;
        num_checks = 0;
        i_sys_rst = 1'b1;
        sfr = '0;
        mon = 5'b11000;
        flags = 8'h00;
        repeat (5) @(posedge i_sys_clk);
        i_sys_rst <= 1'b0;
        rd(ADDR_PERIPHERAL_CONFIG, 8'h60);
        rd(ADDR_POWER_IRQ_ENABLE, 8'h00);
        rd(8'h00, 8'h00);
        wr(ADDR_PERIPHERAL_CONFIG, 8'hFF);
        rd(ADDR_PERIPHERAL_CONFIG, 8'h6B);
        chk("ref", {7'h00, ref_on}, 8'h01);
        // every receive pin code
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_PERIPHERAL_CONFIG, 8'(i));
            repeat (2) @(posedge i_sys_clk);
            #1;
            chk("rxfn", {6'h00, rx_sel, rx_wake}, (i == 1) ? 8'h02 : (i == 3) ? 8'h03 : 8'h00);
        end
        wr(ADDR_POWER_IRQ_ENABLE, 8'hFF);
        rd(ADDR_POWER_IRQ_ENABLE, 8'hAF);
        // each enable against its own flag and the others
        foreach (pos[k]) begin
            wr(ADDR_POWER_IRQ_ENABLE, 8'h01 << pos[k]);
            @(posedge i_sys_clk) flags <= 8'h01 << pos[k];
            @(posedge i_sys_clk);
            #1;
            chk("irq flag", {7'h00, irq_flag}, 8'h01);
            repeat (2) @(posedge i_sys_clk);
            #1;
            chk("irq on", {7'h00, irq}, 8'h01);
            chk("flag drop", {7'h00, irq_flag}, 8'h00);
            @(posedge i_sys_clk) flags <= ~(8'h01 << pos[k]);
            repeat (3) @(posedge i_sys_clk);
            #1;
            chk("irq off", {7'h00, irq}, 8'h00);
            @(posedge i_sys_clk) flags <= 8'h00;
        end
        @(posedge i_sys_clk) mon.pll_unlock <= 1'b1;
        @(posedge i_sys_clk) mon.pll_unlock <= 1'b0;
        rd(ADDR_PERIPHERAL_CONFIG, 8'h73);
        wr(ADDR_ADC_START_REGISTER, 8'h80);
        rd(ADDR_PERIPHERAL_CONFIG, 8'h63);
        @(posedge i_sys_clk) mon <= 5'b11011;
        @(posedge i_sys_clk) mon.rx_edge <= 1'b0;
        rd(ADDR_PERIPHERAL_CONFIG, 8'hE3);
        @(posedge i_sys_clk) mon <= 5'b00000;
        repeat (2) @(posedge i_sys_clk);
        rd(ADDR_PERIPHERAL_CONFIG, 8'h83);
        @(posedge i_sys_clk) mon <= 5'b11000;
        // restore strobe within a few cycles
        num_checks++;
        for (int t = 0; t <= 4; t++) begin
            @(posedge i_sys_clk);
            #1;
            if (restore === 1'b1) break;
            if (t == 4) chk("restore", 8'h00, 8'h01);
        end
        rd(ADDR_PERIPHERAL_CONFIG, 8'hE3);
        test_done();
    end
endmodule // testbench
